// >>> rtl/etu_pkg.sv
// Constants, register map and types for the external trigger unit
// Function
// - Report present comparator level: 0 below threshold, 1 above
// - Hold host-programmable threshold code; full scale corresponds to 3.3 V
// - Scan trigger gates start of scans and mass measurements until condition
// - Preparations proceed after scan command; measurement start withheld until trigger
// - Scan trigger enable: 1 turns gating on, 0 turns it off
// - Scan condition code: 0 low, 1 high, 2 rising, 3 falling
// - Level modes start gated scan while input below or above threshold
// - Edge modes start gated scan on below-above or above-below transition
// - Scan trigger conditions detected with roughly one millisecond resolution
// - Software trigger enable: 1 enables state machine, 0 disables it
// - Software condition uses same encoding as scan condition
// - While armed, move to Fired as soon as condition detected
// - Software level modes fire on level, edge modes on transition
// - Fired query returns 0 not fired, 1 fired
// - Reset command returns machine to Enabled; re-arm needed to fire again
// - State query encodes 0 Off, 1 Enabled, 2 Armed, 3 Fired
// - Software trigger conditions sampled and updated about every millisecond
package etu_pkg;
  // Register byte offsets
  localparam logic [11:0] ETU_OFS_CTRL   = 12'h000;
  localparam logic [11:0] ETU_OFS_THRESH = 12'h004;
  localparam logic [11:0] ETU_OFS_STATUS = 12'h008;
  localparam logic [11:0] ETU_OFS_CMD    = 12'h00C;
  // Control fields
  localparam int ETU_CTRL_SCAN_EN = 0;
  localparam int ETU_CTRL_SCAN_MODE_LSB = 1;
  localparam int ETU_CTRL_SW_EN = 4;
  localparam int ETU_CTRL_SW_MODE_LSB = 5;
  // Command bits (write one to act)
  localparam int ETU_CMD_ARM = 0;
  localparam int ETU_CMD_RESET = 1;
  // Status fields
  localparam int ETU_STAT_LEVEL = 0;
  localparam int ETU_STAT_FIRED = 1;
  localparam int ETU_STAT_STATE_LSB = 2;
  localparam int ETU_STAT_SCAN_WAIT = 4;
  // Threshold code width and reset value (mid scale of 3.3 V range)
  localparam int ETU_THRESH_W = 12;
  localparam logic [11:0] ETU_THRESH_RST = 12'h800;
  localparam logic [11:0] ETU_THRESH_FULL_MV = 12'hCE4; // 3300 mV
  // Sampling period
  localparam int ETU_CLK_MHZ = 250;
  localparam int ETU_SAMPLE_US = 1000;
  localparam int ETU_SAMPLE_CYC = ETU_SAMPLE_US * ETU_CLK_MHZ;
  // Trigger conditions
  typedef enum logic [1:0] {
    ETU_LVL_LOW  = 2'h0,
    ETU_LVL_HIGH = 2'h1,
    ETU_RISING   = 2'h2,
    ETU_FALLING  = 2'h3
  } etu_mode_t;
  // Software trigger states, query codes 0..3
  typedef enum logic [1:0] {
    ETU_OFF,
    ETU_ENABLED,
    ETU_ARMED,
    ETU_FIRED
  } etu_state_t;
endpackage

// >>> rtl/etu_trigger.sv
// External trigger unit: comparator sampling, scan gate, software trigger, APB slave
`timescale 1ns/10ps
module etu_trigger #(
  parameter int SAMPLE_CYC = etu_pkg::ETU_SAMPLE_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Comparator result from the trigger pin, high when above threshold
  input  wire logic        cmpAbove,
  // Threshold code to the comparator DAC
  output logic [etu_pkg::ETU_THRESH_W-1:0] thresholdCode,
  // Scan sequencer handshake
  input  wire logic        scanRequest,
  output logic             scanWaiting,
  output logic             scanStart
);
  import etu_pkg::*;

  logic              scanEn;
  etu_mode_t         scanMode;
  logic              swEn;
  etu_mode_t         swMode;
  etu_state_t        swState;
  logic [31:0]       tickCnt;
  logic              tick;
  logic              sync1;
  logic              sync2;
  logic              levelNow;
  logic              levelPrev;
  logic              samplesValid;
  logic              scanHit;
  logic              swHit;
  logic              wrEn;
  logic              rdEn;
  logic              addrOk;
  logic              armCmd;
  logic              resetCmd;
  logic              next_scanWaiting;

  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;
  assign addrOk = (paddr == ETU_OFS_CTRL) || (paddr == ETU_OFS_THRESH) ||
                  (paddr == ETU_OFS_STATUS) || (paddr == ETU_OFS_CMD);
  assign pslverr = psel && penable && !addrOk;
  assign armCmd = wrEn && (paddr == ETU_OFS_CMD) && pwdata[ETU_CMD_ARM];
  assign resetCmd = wrEn && (paddr == ETU_OFS_CMD) && pwdata[ETU_CMD_RESET];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scanEn <= 1'b0;
      scanMode <= ETU_LVL_LOW;
      swEn <= 1'b0;
      swMode <= ETU_LVL_LOW;
    end else if (wrEn && paddr == ETU_OFS_CTRL) begin
      scanEn <= pwdata[ETU_CTRL_SCAN_EN];
      scanMode <= etu_mode_t'(pwdata[ETU_CTRL_SCAN_MODE_LSB +: 2]);
      swEn <= pwdata[ETU_CTRL_SW_EN];
      swMode <= etu_mode_t'(pwdata[ETU_CTRL_SW_MODE_LSB +: 2]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      thresholdCode <= ETU_THRESH_RST;
    end else if (wrEn && paddr == ETU_OFS_THRESH) begin
      thresholdCode <= pwdata[ETU_THRESH_W-1:0];
    end
  end

  // same tick paces the state machine
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tickCnt <= 32'h0;
      tick <= 1'b0;
    end else if (tickCnt == 32'(SAMPLE_CYC - 1)) begin
      tickCnt <= 32'h0;
      tick <= 1'b1;
    end else begin
      tickCnt <= tickCnt + 32'h1;
      tick <= 1'b0;
    end
  end

  // Two-stage synchroniser; first stage is read only by the second
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= cmpAbove;
      sync2 <= sync1;
    end
  end

  // sample on ticks, keep previous sample
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      levelNow <= 1'b0;
      levelPrev <= 1'b0;
      samplesValid <= 1'b0;
    end else if (tick) begin
      levelNow <= sync2;
      levelPrev <= levelNow;
      samplesValid <= 1'b1;
    end
  end

  // Condition test shared by both trigger contexts
  function automatic logic etu_cond(input etu_mode_t m, input logic now,
                                    input logic prev, input logic valid);
    logic r;
    r = 1'b0;
    unique case (m)
      ETU_LVL_LOW:  r = !now;
      ETU_LVL_HIGH: r = now;
      ETU_RISING:   r = valid && now && !prev;
      ETU_FALLING:  r = valid && !now && prev;
    endcase
    return r;
  endfunction

  assign scanHit = tick && etu_cond(scanMode, sync2, levelNow, samplesValid);
  assign swHit = tick && etu_cond(swMode, sync2, levelNow, samplesValid);

  always_comb begin
    next_scanWaiting = scanWaiting;
    if (scanRequest) begin
      next_scanWaiting = scanEn;
    end else if (scanWaiting && (scanHit || !scanEn)) begin
      next_scanWaiting = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scanWaiting <= 1'b0;
      scanStart <= 1'b0;
    end else begin
      scanWaiting <= next_scanWaiting;
      scanStart <= (scanRequest && !scanEn) ||
                   (!scanRequest && scanWaiting && (scanHit || !scanEn));
    end
  end

  // Software trigger state machine
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      swState <= ETU_OFF;
    end else if (!swEn) begin
      swState <= ETU_OFF;
    end else begin
      unique case (swState)
        ETU_OFF: swState <= ETU_ENABLED;
        ETU_ENABLED: begin
          if (armCmd) begin
            swState <= ETU_ARMED;
          end
        end
        ETU_ARMED: begin
          if (swHit) begin
            swState <= ETU_FIRED;
          end else if (resetCmd) begin
            swState <= ETU_ENABLED;
          end
        end
        ETU_FIRED: begin
          if (resetCmd) begin
            swState <= ETU_ENABLED;
          end
        end
      endcase
    end
  end

  // Read mux, registered in the setup cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0;
      unique case (paddr)
        ETU_OFS_CTRL: begin
          prdata[ETU_CTRL_SCAN_EN] <= scanEn;
          prdata[ETU_CTRL_SCAN_MODE_LSB +: 2] <= scanMode;
          prdata[ETU_CTRL_SW_EN] <= swEn;
          prdata[ETU_CTRL_SW_MODE_LSB +: 2] <= swMode;
        end
        ETU_OFS_THRESH: prdata[ETU_THRESH_W-1:0] <= thresholdCode;
        ETU_OFS_STATUS: begin
          prdata[ETU_STAT_LEVEL] <= sync2;
          prdata[ETU_STAT_FIRED] <= (swState == ETU_FIRED);
          prdata[ETU_STAT_STATE_LSB +: 2] <= swState;
          prdata[ETU_STAT_SCAN_WAIT] <= scanWaiting;
        end
        default: prdata <= 32'h0;
      endcase
    end
  end

  // Checks
  property p_disable_off;
    @(posedge ref_clk) disable iff (rst) !swEn |=> swState == ETU_OFF;
  endproperty
  a_disable_off: assert property (p_disable_off) else $error("not off");

  property p_fire;
    @(posedge ref_clk) disable iff (rst)
      swEn && swState == ETU_ARMED && swHit |=> swState == ETU_FIRED;
  endproperty
  a_fire: assert property (p_fire) else $error("armed did not fire");

  property p_reset_cmd;
    @(posedge ref_clk) disable iff (rst)
      swEn && swState == ETU_FIRED && resetCmd |=> swState == ETU_ENABLED;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset ignored");

  property p_no_arm;
    @(posedge ref_clk) disable iff (rst)
      swState == ETU_OFF |=> swState != ETU_ARMED;
  endproperty
  a_no_arm: assert property (p_no_arm) else $error("armed from off");

  property p_fire_tick;
    @(posedge ref_clk) disable iff (rst)
      swState != ETU_FIRED ##1 swState == ETU_FIRED |-> $past(tick);
  endproperty
  a_fire_tick: assert property (p_fire_tick) else $error("fired off tick");

  property p_gate;
    @(posedge ref_clk) disable iff (rst)
      scanWaiting && !scanHit && scanEn && !scanRequest |=> !scanStart;
  endproperty
  a_gate: assert property (p_gate) else $error("scan not held");

  property p_start;
    @(posedge ref_clk) disable iff (rst)
      scanWaiting && scanHit && !scanRequest |=> scanStart && !scanWaiting;
  endproperty
  a_start: assert property (p_start) else $error("scan not started");

  property p_tick_period;
    @(posedge ref_clk) disable iff (rst) tick |=> !tick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick too fast");

  // Independent cycle count since the last tick; catches a wrong divider end point
  logic [31:0] tickGap;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tickGap <= 32'h0;
    end else if (tick) begin
      tickGap <= 32'h1;
    end else begin
      tickGap <= tickGap + 32'h1;
    end
  end

  property p_tick_gap;
    @(posedge ref_clk) disable iff (rst) tick |-> tickGap == 32'(SAMPLE_CYC);
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick period wrong");

  property p_rising;
    @(posedge ref_clk) disable iff (rst)
      scanMode == ETU_RISING && scanHit |-> sync2 && !levelNow;
  endproperty
  a_rising: assert property (p_rising) else $error("bad rising");

  c_fire: cover property (@(posedge ref_clk) swState == ETU_ARMED ##1 swState == ETU_FIRED);
  c_rearm: cover property (@(posedge ref_clk) swState == ETU_FIRED ##1 swState == ETU_ENABLED);
  c_scan: cover property (@(posedge ref_clk) scanWaiting ##1 scanStart);
  c_release: cover property (@(posedge ref_clk) scanWaiting && !scanEn ##1 scanStart);
  c_off: cover property (@(posedge ref_clk) swState == ETU_ENABLED && !swEn ##1 swState == ETU_OFF);
endmodule

// >>> tb/etu_apparatus.sv
// External apparatus model: trigger pin voltage seen by the comparator
`timescale 1ns/10ps
module etu_apparatus (
  // Pin voltage in millivolts, set by the bench
  input  wire logic [11:0] pinMv,
  // Threshold code from the block
  input  wire logic [11:0] thresholdCode,
  // Comparator result, high above threshold
  output logic             cmpAbove
);
  // range tops at 3.3 V
  // Full-scale code stands for 3300 mV; no hysteresis, like a bare comparator
  always_comb begin
    cmpAbove = (32'(pinMv) * 32'hFFF / 32'(etu_pkg::ETU_THRESH_FULL_MV)) > 32'(thresholdCode);
  end
endmodule

// >>> tb/external_trigger_unit_test.sv
// Self-checking bench for the external trigger unit
`timescale 1ns/10ps
module external_trigger_unit_test;
  import etu_pkg::*;
  localparam int SC = 10;
  localparam logic [11:0] LO = 12'h1F4; // 500 mV
  localparam logic [11:0] HI = 12'hBB8; // 3000 mV
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        scanRequest = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [11:0] pinMv = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        slvErr;
  logic        pready;
  logic        pslverr;
  logic        cmpAbove;
  logic        scanWaiting;
  logic        scanStart;
  logic [11:0] thresholdCode;
  int          miscompares = 0;
  int          totalChecks = 0;

  // Design with a short sampling period
  etu_trigger #(.SAMPLE_CYC(SC)) uut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmpAbove(cmpAbove), .thresholdCode(thresholdCode),
    .scanRequest(scanRequest), .scanWaiting(scanWaiting), .scanStart(scanStart));
  etu_apparatus pin (.pinMv(pinMv), .thresholdCode(thresholdCode), .cmpAbove(cmpAbove));

  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;

  task automatic conclude();
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chkWord(input string nm, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkBit(input string nm, input logic e, input logic g);
    chkWord(nm, {31'h0, e}, {31'h0, g});
  endtask

  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      conclude();
    end
    rd = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Threshold register, level readback, unmapped and write-only places
  task automatic regCase();
    apb(1'b0, ETU_OFS_THRESH, 32'h0);
    chkWord("thresh reset", {20'h0, ETU_THRESH_RST}, rd);
    chkWord("dac reset", {20'h0, ETU_THRESH_RST}, {20'h0, thresholdCode});
    pinMv <= LO;
    apb(1'b1, ETU_OFS_THRESH, 32'h100);
    repeat (3 * SC) @(posedge ref_clk);
    apb(1'b0, ETU_OFS_STATUS, 32'h0);
    chkBit("level low threshold", 1'b1, rd[ETU_STAT_LEVEL]);
    apb(1'b0, ETU_OFS_THRESH, 32'h0);
    chkWord("thresh write", 32'h100, rd);
    chkWord("dac write", 32'h100, {20'h0, thresholdCode});
    apb(1'b1, ETU_OFS_THRESH, 32'h800);
    repeat (3 * SC) @(posedge ref_clk);
    apb(1'b0, ETU_OFS_STATUS, 32'h0);
    chkBit("level mid threshold", 1'b0, rd[ETU_STAT_LEVEL]);
    apb(1'b0, 12'h010, 32'h0);
    chkBit("unmapped error", 1'b1, slvErr);
    chkWord("unmapped data", 32'h0, rd);
    apb(1'b0, ETU_OFS_CMD, 32'h0);
    chkWord("cmd reads zero", 32'h0, rd);
  endtask

  // Gate off: start follows the request at once; dropping the gate frees a held scan
  task automatic scanOff();
    int n;
    apb(1'b1, ETU_OFS_CTRL, 32'h0);
    scanRequest <= 1'b1;
    @(posedge ref_clk);
    scanRequest <= 1'b0;
    @(posedge ref_clk);
    chkBit("ungated start", 1'b1, scanStart);
    pinMv <= LO;
    apb(1'b1, ETU_OFS_CTRL, 32'h3);
    scanRequest <= 1'b1;
    @(posedge ref_clk);
    scanRequest <= 1'b0;
    apb(1'b0, ETU_OFS_STATUS, 32'h0);
    chkBit("status waiting", 1'b1, rd[ETU_STAT_SCAN_WAIT]);
    apb(1'b0, ETU_OFS_CTRL, 32'h0);
    chkWord("ctrl readback", 32'h3, rd);
    apb(1'b1, ETU_OFS_CTRL, 32'h0);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (scanStart !== 1'b1 && n < 4);
    chkBit("released start", 1'b1, scanStart);
    if (scanStart !== 1'b1) begin
      conclude();
    end
  endtask

  // Gate on: held while the condition is absent, released once it appears
  task automatic scanCase(input logic [1:0] m);
    logic up;
    logic seen;
    int   n;
    up = (m == 2'h1 || m == 2'h2);
    seen = 1'b0;
    pinMv <= up ? LO : HI;
    apb(1'b1, ETU_OFS_CTRL, {29'h0, m, 1'b1});
    repeat (3 * SC) @(posedge ref_clk);
    scanRequest <= 1'b1;
    @(posedge ref_clk);
    scanRequest <= 1'b0;
    repeat (3 * SC) begin
      @(posedge ref_clk);
      seen |= (scanStart === 1'b1);
    end
    chkBit("held start", 1'b0, seen);
    chkBit("waiting", 1'b1, scanWaiting);
    pinMv <= up ? HI : LO;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (scanStart !== 1'b1 && n < 4 * SC + 8);
    chkBit("gated start", 1'b1, scanStart);
    if (scanStart !== 1'b1) begin
      conclude();
    end
    @(posedge ref_clk);
    chkBit("waiting cleared", 1'b0, scanWaiting);
  endtask

  // Software trigger walk through every state
  task automatic swCase(input logic [1:0] m);
    logic f;
    f = (m == 2'h1 || m == 2'h2);
    pinMv <= f ? LO : HI;
    apb(1'b1, ETU_OFS_CTRL, {25'h0, m, 5'h10});
    repeat (3 * SC) @(posedge ref_clk);
    apb(1'b0, ETU_OFS_STATUS, 32'h0);
    chkWord("enabled", {28'h0, 2'h1, 1'b0, ~f}, {28'h0, rd[3:0]});
    apb(1'b1, ETU_OFS_CMD, 32'h1);
    repeat (3 * SC) @(posedge ref_clk);
    apb(1'b0, ETU_OFS_STATUS, 32'h0);
    chkWord("armed", {28'h0, 2'h2, 1'b0, ~f}, {28'h0, rd[3:0]});
    pinMv <= f ? HI : LO;
    repeat (3 * SC) @(posedge ref_clk);
    apb(1'b0, ETU_OFS_STATUS, 32'h0);
    chkWord("fired", {28'h0, 2'h3, 1'b1, f}, {28'h0, rd[3:0]});
    apb(1'b1, ETU_OFS_CMD, 32'h2);
    repeat (3 * SC) @(posedge ref_clk);
    apb(1'b0, ETU_OFS_STATUS, 32'h0);
    chkWord("reset", {28'h0, 2'h1, 1'b0, f}, {28'h0, rd[3:0]});
    apb(1'b1, ETU_OFS_CTRL, 32'h0);
    apb(1'b1, ETU_OFS_CMD, 32'h1);
    repeat (2) @(posedge ref_clk);
    apb(1'b0, ETU_OFS_STATUS, 32'h0);
    chkWord("off", {28'h0, 2'h0, 1'b0, f}, {28'h0, rd[3:0]});
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    regCase();
    scanOff();
    for (int m = 0; m < 4; m++) begin
      scanCase(2'(m));
    end
    for (int m = 0; m < 4; m++) begin
      swCase(2'(m));
    end
    conclude();
  end
endmodule
